// ---- hw/single_wire_slot_timing_master.sv ----
// Purpose: time-slot generator of a single-wire open-drain bus master
// Assumes: line_i and all requests are synchronous to clk_i
// Notes: requests are taken only while idle; the divisor sets the tick length
//
// Overview of operation
// (RULE1) master makes reset, write and read signalling
// (RULE2) reset low 626 or 63 ticks
// (RULE3) reset high phase 636 or 74 ticks
// (RULE4) sample presence after fall, or on timeout
// (RULE5) presence sample delay per speed and mode
// (RULE6) slave waits, then pulls presence low
// (RULE7) write one releases line after short low
// (RULE8) write zero holds line low long
// (RULE9) slave samples written level mid slot
// (RULE10) read slot starts with short low pulse
// (RULE11) slave holds low for zero, releases for one
// (RULE12) read data sampled after slot start
// (RULE13) each slot lasts its full slot time
// (RULE14) recovery time follows each slot
// (RULE15) all timing counted in timebase ticks
// (RULE16) pull-up window around presence detect
// (RULE17) presence recovery pull-up after long delay
// (RULE18) write one recovery pull-up window
// (RULE19) write zero window, turn-on and turn-off delays
// (RULE20) last bit holds pull-up or short window
// (RULE21) read recovery pull-up waits for line high
// (RULE22) recovery pull-up enables once line high
// (RULE23) pull-up only when allowed and line free
// (RULE24) idle supply keeps pull-up on when idle
// (RULE25) long line moves release, sample, recovery
// (RULE26) presence masking drives edge, result zero
// (RULE27) windows count divided-clock ticks per mode
`timescale 1ns/100ps

module single_wire_slot_timing_master
    import owm_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DIV_W-1:0] tick_divisor_i,
    input wire logic start_reset_i,
    input wire logic start_slot_i,
    input wire logic slot_read_i,
    input wire logic write_value_i,
    input wire logic first_bit_i,
    input wire logic last_bit_i,
    input wire logic overdrive_select_i,
    input wire logic long_line_timing_i,
    input wire logic presence_masking_i,
    input wire logic strong_pullup_allow_i,
    input wire logic strong_pullup_idle_supply_i,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    output logic strong_pullup_enable_n_o,
    output logic busy_o,
    output logic slot_done_o,
    output logic presence_done_o,
    output logic presence_result_o,
    output logic read_bit_o
);
    `include "owm_timing_regs.svh"

    generate
        if (DIV_W < 7) begin : g_div_check
            $error("divisor too narrow for a microsecond tick");
        end
    endgenerate

    // ****************************************************************
    // state
    // ****************************************************************
    state_t state;
    state_t next_state;
    cnt_t cnt;
    cnt_t reach;
    cnt_t pres_cnt;
    cnt_t pres_reach;
    logic tick;
    logic clear_cnt;
    logic line_q;
    logic fell;
    logic sampled;
    logic rd_sampled;
    logic slot_read;
    logic wr_val;
    logic first;
    logic last;
    logic hold;
    cnt_t pu_dly;
    cnt_t pu_len;
    logic pu_wait;
    logic pu_pend2;

    // timebase enable; all windows advance on it
    owm_tick_divider #(
        .DIV_W(DIV_W)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(tick_divisor_i),
        .tick_o(tick) // (RULE15)
    );

    // ****************************************************************
    // per-mode window lengths
    // ****************************************************************
    logic od;
    logic ll;
    cnt_t t_rstl;
    cnt_t t_rsth;
    cnt_t t_pds;
    cnt_t t_pdwait;
    cnt_t t_ppm_at;
    cnt_t t_ppm_end;
    cnt_t t_low1;
    cnt_t t_low;
    cnt_t t_rdv;
    cnt_t t_slot;
    cnt_t t_rec;
    cnt_t t_on1;
    cnt_t t_on_slot;
    cnt_t t_dly2_rem;
    cnt_t t_off;

    // long line only applies at standard speed
    assign od = overdrive_select_i;
    assign ll = long_line_timing_i & ~overdrive_select_i; // (RULE25)
    assign t_rstl = od ? cnt_t'(`OWM_RSTL_OD) : cnt_t'(`OWM_RSTL_STD); // (RULE2)
    assign t_rsth = od ? cnt_t'(`OWM_RSTH_OD) : cnt_t'(`OWM_RSTH_STD); // (RULE3)
    assign t_pds = od ? cnt_t'(`OWM_PDS_OD) : ll ? cnt_t'(`OWM_PDS_LL)
        : cnt_t'(`OWM_PDS_STD); // (RULE5)
    assign t_pdwait = od ? cnt_t'(`OWM_PDWAIT_OD) : cnt_t'(`OWM_PDWAIT_STD);
    assign t_ppm_at = od ? cnt_t'(`OWM_PPM_AT_OD) : cnt_t'(`OWM_PPM_AT_STD);
    assign t_ppm_end = od ? cnt_t'(`OWM_PPM_AT_OD + `OWM_PPM_LEN_OD)
        : cnt_t'(`OWM_PPM_AT_STD + `OWM_PPM_LEN_STD);
    assign t_low1 = od ? cnt_t'(`OWM_LOW1_OD) : ll ? cnt_t'(`OWM_LOW1_LL)
        : cnt_t'(`OWM_LOW1_STD); // (RULE7)
    // read pulse is one tick, the shortest legal start
    assign t_low = slot_read ? cnt_t'(`OWM_RDLOW) : wr_val ? t_low1
        : od ? cnt_t'(`OWM_LOW0_OD) : cnt_t'(`OWM_LOW0_STD); // (RULE8) (RULE10)
    assign t_rdv = od ? cnt_t'(`OWM_RDV_OD) : ll ? cnt_t'(`OWM_RDV_LL)
        : cnt_t'(`OWM_RDV_STD); // (RULE12)
    assign t_slot = od ? cnt_t'(`OWM_SLOT_OD) : cnt_t'(`OWM_SLOT_STD); // (RULE13)
    assign t_rec = od ? cnt_t'(`OWM_REC_OD) : ll ? cnt_t'(`OWM_REC_LL)
        : cnt_t'(`OWM_REC_STD); // (RULE14)
    assign t_on1 = od ? cnt_t'(`OWM_ON1_OD) : cnt_t'(`OWM_ON1_STD);
    // reads use the write zero window; value unknown up front
    assign t_on_slot = (wr_val & ~slot_read)
        ? (od ? cnt_t'(`OWM_ON3_OD) : cnt_t'(`OWM_ON3_STD))
        : (od ? cnt_t'(`OWM_ON4_OD) : cnt_t'(`OWM_ON4_STD)); // (RULE18) (RULE19)
    // second presence delay counts from the sample
    assign t_dly2_rem = od ? cnt_t'(`OWM_DLY2_OD - `OWM_DLY1 - `OWM_ON1_OD)
        : cnt_t'(`OWM_DLY2_STD - `OWM_DLY1 - `OWM_ON1_STD); // (RULE17)
    assign t_off = first ? cnt_t'(`OWM_OFF2_FIRST) : cnt_t'(`OWM_OFF2); // (RULE19)

    // ****************************************************************
    // sequencing
    // ****************************************************************
    logic go_reset;
    logic go_slot;
    logic sample_pres;
    logic sample_rd;
    logic arm_slot;
    logic ppm_drive;
    logic drive_low;
    logic await_data;
    logic pu_on;
    logic next_pu;

    assign reach = cnt_t'(cnt + cnt_t'(1));
    assign pres_reach = cnt_t'(pres_cnt + cnt_t'(1));
    // reset wins over a slot request
    assign go_reset = (state == ST_IDLE) & start_reset_i; // (RULE1)
    assign go_slot = (state == ST_IDLE) & ~start_reset_i & start_slot_i; // (RULE1)
    assign sample_pres = (state == ST_RST_HIGH) & tick & ~sampled
        & ((fell & pres_reach == t_pds) | (~fell & reach == t_pdwait)); // (RULE4)
    assign sample_rd = slot_read & ~rd_sampled & tick & reach == t_rdv
        & (state == ST_SLOT_LOW | state == ST_SLOT_HIGH); // (RULE12)
    assign arm_slot = (state == ST_SLOT_HIGH) & tick & reach == t_slot;
    assign ppm_drive = (state == ST_RST_HIGH) & presence_masking_i
        & cnt >= t_ppm_at & cnt < t_ppm_end; // (RULE26)
    assign drive_low = (state == ST_RST_LOW) | (state == ST_SLOT_LOW) | ppm_drive;
    assign await_data = ((state == ST_RST_HIGH) & ~sampled)
        | ((state == ST_SLOT_HIGH) & slot_read & ~rd_sampled);
    assign pu_on = (pu_dly == '0) & (pu_len != '0) & ~pu_wait;
    // pull-up off while the line is pulled or answered
    assign next_pu = strong_pullup_allow_i & ~drive_low & ~await_data
        & state != ST_RST_OFF & state != ST_SLOT_OFF
        & (pu_on | (hold & (state == ST_REC | state == ST_IDLE))
        | (strong_pullup_idle_supply_i & state == ST_IDLE)); // (RULE23) (RULE24)

    // state transitions; windows end on the tick that reaches their length
    always_comb begin
        next_state = state;
        clear_cnt = 1'b0;
        unique case (state)
            ST_IDLE: begin
                clear_cnt = 1'b1;
                if (go_reset) begin
                    next_state = ST_RST_OFF;
                end else if (go_slot) begin
                    next_state = ST_SLOT_OFF;
                end
            end
            ST_RST_OFF: begin
                if (tick && reach == cnt_t'(`OWM_OFF1)) begin
                    next_state = ST_RST_LOW; // (RULE16)
                    clear_cnt = 1'b1;
                end
            end
            ST_RST_LOW: begin
                if (tick && reach == t_rstl) begin
                    next_state = ST_RST_HIGH; // (RULE2)
                    clear_cnt = 1'b1;
                end
            end
            ST_RST_HIGH: begin
                if (tick && reach == t_rsth) begin
                    next_state = ST_IDLE; // (RULE3)
                    clear_cnt = 1'b1;
                end
            end
            ST_SLOT_OFF: begin
                if (tick && reach == t_off) begin
                    next_state = ST_SLOT_LOW;
                    clear_cnt = 1'b1;
                end
            end
            ST_SLOT_LOW: begin
                if (tick && reach == t_low) begin
                    next_state = ST_SLOT_HIGH; // (RULE7) (RULE8) (RULE10)
                end
            end
            ST_SLOT_HIGH: begin
                if (arm_slot) begin
                    next_state = ST_REC; // (RULE13)
                    clear_cnt = 1'b1;
                end
            end
            ST_REC: begin
                if (tick && reach == t_rec) begin
                    next_state = ST_IDLE; // (RULE14)
                    clear_cnt = 1'b1;
                end
            end
        endcase
    end

    // state and tick counter; one count spans slot low and high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= clear_cnt ? '0 : tick ? reach : cnt; // (RULE27)
        end
    end

    // request capture at slot start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_read <= 1'b0;
            wr_val <= 1'b0;
            first <= 1'b0;
            last <= 1'b0;
        end else if (go_slot) begin
            slot_read <= slot_read_i;
            wr_val <= write_value_i;
            first <= first_bit_i;
            last <= last_bit_i;
        end
    end

    // ****************************************************************
    // presence and read sampling
    // ****************************************************************
    // fall after release starts the sample delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_q <= 1'b1;
            fell <= 1'b0;
            pres_cnt <= '0;
            sampled <= 1'b0;
        end else begin
            line_q <= line_i;
            if (state == ST_RST_LOW) begin
                fell <= 1'b0;
                pres_cnt <= '0;
                sampled <= 1'b0;
            end else if (state == ST_RST_HIGH) begin
                fell <= fell | (line_q & ~line_i); // (RULE4)
                pres_cnt <= (fell & tick) ? pres_reach : pres_cnt;
                sampled <= sampled | sample_pres;
            end
        end
    end

    // results; masking always reports a device
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presence_result_o <= 1'b0;
            read_bit_o <= 1'b0;
            rd_sampled <= 1'b0;
        end else begin
            if (sample_pres) begin
                presence_result_o <= presence_masking_i ? 1'b0 : line_i; // (RULE4) (RULE26)
            end
            if (go_slot) begin
                rd_sampled <= 1'b0;
            end else if (sample_rd) begin
                rd_sampled <= 1'b1;
                read_bit_o <= line_i; // (RULE12)
            end
        end
    end

    // ****************************************************************
    // strong pull-up windows
    // ****************************************************************
    // delay, wait for high if asked, then count on time
    always_ff @(posedge clk_i) begin
        if (rst_i || go_reset || go_slot) begin
            pu_dly <= '0;
            pu_len <= '0;
            pu_wait <= 1'b0;
            pu_pend2 <= 1'b0;
        end else if (sample_pres) begin
            pu_dly <= cnt_t'(`OWM_DLY1); // (RULE16)
            pu_len <= t_on1;
            pu_wait <= 1'b0;
            pu_pend2 <= 1'b1;
        end else if (arm_slot) begin
            pu_dly <= cnt_t'(`OWM_DLY3); // (RULE19)
            pu_len <= t_on_slot; // (RULE18)
            pu_wait <= 1'b1; // (RULE21)
        end else if (tick) begin
            if (pu_dly != '0) begin
                pu_dly <= cnt_t'(pu_dly - cnt_t'(1));
            end else if (pu_wait) begin
                pu_wait <= ~line_i; // (RULE21) (RULE22)
            end else if (pu_len != '0) begin
                pu_len <= cnt_t'(pu_len - cnt_t'(1));
                if (pu_len == cnt_t'(1) && pu_pend2) begin
                    pu_dly <= t_dly2_rem; // (RULE17)
                    pu_len <= cnt_t'(`OWM_ON2);
                    pu_wait <= 1'b1; // (RULE22)
                    pu_pend2 <= 1'b0;
                end
            end
        end
    end

    // last-bit hold lasts until the next reset or slot
    always_ff @(posedge clk_i) begin
        if (rst_i || go_reset || go_slot) begin
            hold <= 1'b0;
        end else if (arm_slot) begin
            hold <= last & strong_pullup_idle_supply_i; // (RULE20)
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // registered outputs; line drive lags state one clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_o <= 1'b0;
            line_oe_o <= 1'b0;
            strong_pullup_enable_n_o <= 1'b1;
            busy_o <= 1'b0;
            slot_done_o <= 1'b0;
            presence_done_o <= 1'b0;
        end else begin
            line_o <= 1'b0;
            line_oe_o <= drive_low; // (RULE1)
            strong_pullup_enable_n_o <= ~next_pu; // (RULE23)
            busy_o <= next_state != ST_IDLE;
            slot_done_o <= (state == ST_REC) & (next_state == ST_IDLE);
            presence_done_o <= (state == ST_RST_HIGH) & (next_state == ST_IDLE);
        end
    end
endmodule

// ---- shared/owm_timing_regs.svh ----
// Purpose: named timing figures of the single-wire slot timer, in timebase ticks
// Assumes: one tick lasts OWM_TB_NS; figures are longest times in us
// Notes: tick counts round down
`ifndef OWM_TIMING_REGS_SVH
`define OWM_TIMING_REGS_SVH

// ****************************************************************
// clock and timebase
// ****************************************************************
`define OWM_CLK_NS 10
`define OWM_TB_NS 1000
`define OWM_TICK_DIV (`OWM_TB_NS / `OWM_CLK_NS)
`define OWM_US_TICKS(us) (((us) * 1000) / `OWM_TB_NS)
`define OWM_CNT_W 10

// ****************************************************************
// reset and presence
// ****************************************************************
`define OWM_RSTL_STD `OWM_US_TICKS(626)
`define OWM_RSTL_OD `OWM_US_TICKS(63)
`define OWM_RSTH_STD `OWM_US_TICKS(636)
`define OWM_RSTH_OD `OWM_US_TICKS(74)
`define OWM_PDS_STD `OWM_US_TICKS(31)
`define OWM_PDS_LL `OWM_US_TICKS(38)
`define OWM_PDS_OD `OWM_US_TICKS(4)
`define OWM_PDWAIT_STD `OWM_US_TICKS(60)
`define OWM_PDWAIT_OD `OWM_US_TICKS(6)
`define OWM_PPM_AT_STD `OWM_US_TICKS(14)
`define OWM_PPM_AT_OD `OWM_US_TICKS(1)
`define OWM_PPM_LEN_STD `OWM_US_TICKS(8)
`define OWM_PPM_LEN_OD `OWM_US_TICKS(1)

// ****************************************************************
// time slots
// ****************************************************************
`define OWM_LOW1_STD `OWM_US_TICKS(6)
`define OWM_LOW1_LL `OWM_US_TICKS(9)
`define OWM_LOW1_OD `OWM_US_TICKS(1)
`define OWM_LOW0_STD `OWM_US_TICKS(78)
`define OWM_LOW0_OD `OWM_US_TICKS(10)
`define OWM_RDLOW `OWM_US_TICKS(1)
`define OWM_RDV_STD `OWM_US_TICKS(15)
`define OWM_RDV_LL `OWM_US_TICKS(25)
`define OWM_RDV_OD `OWM_US_TICKS(2)
`define OWM_SLOT_STD `OWM_US_TICKS(86)
`define OWM_SLOT_OD `OWM_US_TICKS(15)
`define OWM_REC_STD `OWM_US_TICKS(8)
`define OWM_REC_LL `OWM_US_TICKS(14)
`define OWM_REC_OD `OWM_US_TICKS(5)

// ****************************************************************
// strong pull-up windows
// ****************************************************************
`define OWM_ON1_STD `OWM_US_TICKS(8)
`define OWM_ON1_OD `OWM_US_TICKS(1)
`define OWM_ON2 `OWM_US_TICKS(10)
`define OWM_ON3_STD `OWM_US_TICKS(64)
`define OWM_ON3_OD `OWM_US_TICKS(9)
`define OWM_ON4_STD `OWM_US_TICKS(8)
`define OWM_ON4_OD `OWM_US_TICKS(1)
`define OWM_DLY1 `OWM_US_TICKS(1)
`define OWM_DLY2_STD `OWM_US_TICKS(499)
`define OWM_DLY2_OD `OWM_US_TICKS(39)
`define OWM_DLY3 `OWM_US_TICKS(1)
`define OWM_OFF1 `OWM_US_TICKS(2)
`define OWM_OFF2 `OWM_US_TICKS(1)
`define OWM_OFF2_FIRST `OWM_US_TICKS(4)

`endif

// ---- shared/owm_pkg.sv ----
// Purpose: types shared by the single-wire slot timer
// Assumes: timing figures come from owm_timing_regs.svh
// Notes: the tick counter width covers the longest window
`include "owm_timing_regs.svh"

package owm_pkg;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [`OWM_CNT_W-1:0] cnt_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_OFF,
        ST_RST_LOW,
        ST_RST_HIGH,
        ST_SLOT_OFF,
        ST_SLOT_LOW,
        ST_SLOT_HIGH,
        ST_REC
    } state_t;
endpackage

// ---- hw/owm_tick_divider.sv ----
// Purpose: divides the system clock down to the one-tick timebase enable
// Assumes: divisor is held stable while the link is busy
// Notes: a divisor of 0 or 1 gives a tick on every clock
`timescale 1ns/100ps

module owm_tick_divider #(
    parameter int DIV_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DIV_W-1:0] divisor_i,
    output logic tick_o
);
    logic [DIV_W-1:0] count;
    logic [DIV_W:0] count_inc;
    logic wrap;

    generate
        if (DIV_W < 2) begin : g_width_check
            $error("divider width too small");
        end
    endgenerate

    // one bit wider, so the increment cannot overflow
    assign count_inc = {1'b0, count} + {{DIV_W{1'b0}}, 1'b1};
    assign wrap = count_inc >= {1'b0, divisor_i};

    // free-running prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            tick_o <= 1'b0;
        end else begin
            count <= wrap ? '0 : count_inc[DIV_W-1:0];
            tick_o <= wrap; // (RULE27)
        end
    end
endmodule

// ---- testbench/owm_master_sva.sv ----
// Purpose: port-level timing checks of the single-wire slot timer
// Assumes: tick divisor held stable while busy
// Notes: bound from the testbench top file
`timescale 1ns/100ps

module owm_master_sva #(
    parameter int DIV_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DIV_W-1:0] tick_divisor_i,
    input wire logic start_reset_i,
    input wire logic presence_masking_i,
    input wire logic strong_pullup_allow_i,
    input wire logic strong_pullup_idle_supply_i,
    input wire logic line_o,
    input wire logic line_oe_o,
    input wire logic strong_pullup_enable_n_o,
    input wire logic busy_o,
    input wire logic slot_done_o,
    input wire logic presence_done_o,
    input wire logic presence_result_o
);
    // ****************************************************************
    // helper: length of the current low drive
    // ****************************************************************
    logic [19:0] oe_run;
    logic [19:0] oe_lim;
    // longest low drive is the reset pulse, plus one tick
    assign oe_lim = 20'(((tick_divisor_i < 2) ? 1 : tick_divisor_i) * 627);
    always_ff @(posedge clk_i) begin
        if (rst_i || !line_oe_o) begin
            oe_run <= 20'h00000;
        end else begin
            oe_run <= oe_run + 20'h00001;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_oe_len; oe_run <= oe_lim; endproperty
    a_oe_len: assert property (p_oe_len) else $error("low drive too long");
    property p_line_zero; line_o == 1'b0; endproperty
    a_line_zero: assert property (p_line_zero) else $error("line value not 0");
    property p_idle_free; !busy_o |-> !line_oe_o; endproperty
    a_idle_free: assert property (p_idle_free) else $error("line driven while idle");
    property p_take; start_reset_i && !busy_o |=> busy_o; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_done_end;
        (slot_done_o || presence_done_o) |-> !busy_o ##1 !(slot_done_o || presence_done_o);
    endproperty
    a_done_end: assert property (p_done_end) else $error("done pulse wrong");
    property p_pu_allow;
        !strong_pullup_allow_i && !$past(strong_pullup_allow_i) |-> strong_pullup_enable_n_o;
    endproperty
    a_pu_allow: assert property (p_pu_allow) else $error("pull-up not allowed");
    property p_pu_drive; line_oe_o |-> strong_pullup_enable_n_o; endproperty
    a_pu_drive: assert property (p_pu_drive) else $error("pull-up while driving");
    property p_idle_sup;
        (!busy_o && strong_pullup_allow_i && strong_pullup_idle_supply_i) [*2]
            |-> !strong_pullup_enable_n_o;
    endproperty
    a_idle_sup: assert property (p_idle_sup) else $error("idle supply off");
    property p_mask; presence_masking_i && presence_done_o |-> !presence_result_o; endproperty
    a_mask: assert property (p_mask) else $error("masked result not 0");
endmodule

// ---- testbench/owm_slave_model.sv ----
// Purpose: behavioural slave on the open-drain line
// Assumes: one timebase tick per clock
// Notes: answers presence and read zero; samples written bits
`timescale 1ns/100ps

module owm_slave_model (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic od_i,
    input wire logic present_i,
    input wire logic answer_zero_i,
    output logic pull_o,
    output logic sampled_o
);
    logic line_q = 1'b1;
    int low_run = 0;
    int wait_cnt = 0;
    int pull_cnt = 0;
    int smp_cnt = 0;
    assign pull_o = (pull_cnt > 0);
    // falls while busy are ignored; no self retrigger
    always @(posedge clk_i) begin
        line_q <= line_i;
        low_run <= line_i ? 0 : low_run + 1;
        if (pull_cnt > 0) pull_cnt <= pull_cnt - 1;
        if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
        if (smp_cnt > 0) smp_cnt <= smp_cnt - 1;
        if (wait_cnt == 1) pull_cnt <= od_i ? 10 : 100;
        if (smp_cnt == 1) sampled_o <= line_i;
        if (line_i && !line_q && low_run > (od_i ? 40 : 400) && present_i) begin
            wait_cnt <= od_i ? 3 : 20;
        end else if (!line_i && line_q && pull_cnt == 0 && wait_cnt == 0) begin
            smp_cnt <= od_i ? 4 : 30;
            if (answer_zero_i) pull_cnt <= od_i ? 5 : 40;
        end
    end
endmodule

// ---- testbench/single_wire_slot_timing_master_tb_top.sv ----
// Purpose: self-checking bench of the single-wire slot timer
// Assumes: divisor 1, so one tick per clock
// Notes: windows are checked with a few clocks of slack
`timescale 1ns/100ps

module single_wire_slot_timing_master_tb_top;
    localparam int DIV_W = 8;
    logic clk_i, rst_i, st_rst, st_slot, rd, wval, fb, lb, od, ll, mask, allow, sup;
    logic present, ans0;
    wire line_w, line_o, oe, pun, busy, sdone, pdone, pres, rbit, pull, smp;
    int errors, n_tests, cyc, oec, puc;
    assign line_w = !(oe || pull);
    single_wire_slot_timing_master #(.DIV_W(DIV_W)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .tick_divisor_i(8'h01), .start_reset_i(st_rst), .start_slot_i(st_slot),
        .slot_read_i(rd), .write_value_i(wval), .first_bit_i(fb), .last_bit_i(lb),
        .overdrive_select_i(od), .long_line_timing_i(ll), .presence_masking_i(mask),
        .strong_pullup_allow_i(allow), .strong_pullup_idle_supply_i(sup), .line_i(line_w),
        .line_o(line_o), .line_oe_o(oe), .strong_pullup_enable_n_o(pun), .busy_o(busy),
        .slot_done_o(sdone), .presence_done_o(pdone), .presence_result_o(pres),
        .read_bit_o(rbit));
    owm_slave_model slave (.clk_i(clk_i), .line_i(line_w), .od_i(od), .present_i(present),
        .answer_zero_i(ans0), .pull_o(pull), .sampled_o(smp));
    always #5 clk_i = ~clk_i;

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // window compare, reports low bound on miss
    task rng(input int got, input int lo, input int hi);
        check(32'(got), (got >= lo && got <= hi) ? 32'(got) : 32'(lo));
    endtask
    task report_and_stop;
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // ****************************************************************
    // one reset or slot; counts drive and pull-up clocks
    // ****************************************************************
    task op(input logic r, input logic is_rd, input logic v, input logic first);
        tk(1);
        {st_rst, st_slot, rd, wval, fb} = {r, !r, is_rd, v, first};
        tk(1);
        {st_rst, st_slot} = '0;
        {cyc, oec, puc} = '0;
        // bounded wait for the done pulse
        while (cyc < 3000 && !(sdone || pdone)) begin
            cyc++;
            if (oe) oec++;
            if (!pun) puc++;
            tk(1);
        end
        // a hung transfer counts as a mismatch
        if (cyc >= 3000) errors++;
        // pull-up windows outlast the done pulse
        repeat (90) begin
            tk(1);
            if (!pun) puc++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end

    initial begin
        {clk_i, st_rst, st_slot, rd, wval, fb, lb, od, ll, mask, sup, ans0, rst_i, allow,
            present} = 15'h0007;
        tk(2);
        rst_i = 0;
        // standard speed: reset with slave present, then write, read and long-line slots
        op(1, 0, 0, 0);
        rng(oec, 625, 628);
        rng(cyc - oec - 2, 634, 640);
        check(pres, 1'b0);
        rng(puc, 16, 20);
        op(0, 0, 1, 0);
        rng(oec, 5, 7);
        check(smp, 1'b1);
        rng(cyc, 93, 98);
        rng(puc, 62, 66);
        op(0, 0, 0, 0);
        rng(oec, 77, 79);
        check(smp, 1'b0);
        rng(puc, 6, 10);
        op(0, 0, 1, 1);
        rng(cyc, 96, 101);
        ans0 = 1;
        op(0, 1, 0, 0);
        rng(oec, 1, 2);
        check(rbit, 1'b0);
        ans0 = 0;
        op(0, 1, 0, 0);
        check(rbit, 1'b1);
        ll = 1;
        op(0, 0, 1, 0);
        rng(oec, 8, 10);
        rng(cyc, 99, 105);
        ll = 0;
        // no slave, then masking
        present = 0;
        op(1, 0, 0, 0);
        check(pres, 1'b1);
        mask = 1;
        op(1, 0, 0, 0);
        check(pres, 1'b0);
        mask = 0;
        present = 1;
        // overdrive
        od = 1;
        op(1, 0, 0, 0);
        rng(oec, 62, 64);
        check(pres, 1'b0);
        rng(puc, 9, 13);
        op(0, 0, 1, 0);
        rng(oec, 1, 2);
        rng(cyc, 20, 25);
        op(0, 0, 0, 0);
        rng(oec, 9, 11);
        od = 0;
        // idle supply, permission
        sup = 1;
        tk(3);
        check(pun, 1'b0);
        allow = 0;
        tk(3);
        check(pun, 1'b1);
        report_and_stop();
    end
endmodule

bind single_wire_slot_timing_master owm_master_sva #(.DIV_W(DIV_W)) u_sva (.clk_i(clk_i),
    .rst_i(rst_i), .tick_divisor_i(tick_divisor_i), .start_reset_i(start_reset_i),
    .presence_masking_i(presence_masking_i), .strong_pullup_allow_i(strong_pullup_allow_i),
    .strong_pullup_idle_supply_i(strong_pullup_idle_supply_i), .line_o(line_o),
    .line_oe_o(line_oe_o), .strong_pullup_enable_n_o(strong_pullup_enable_n_o),
    .busy_o(busy_o), .slot_done_o(slot_done_o), .presence_done_o(presence_done_o),
    .presence_result_o(presence_result_o));
